// file: pab_alert_mask_bank.sv
// Alert mask bank: mask registers, transaction decode, link crossing and alert drive.
`include "pab_cfg.svh"

module pab_alert_mask_bank
   import pab_pkg::*;
(
   input wire logic clk, // Device clock, 10 MHz.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic link_clk, // Clock of the bus protocol engine.
   input wire logic txn_valid, // Decoded transaction offered.
   output logic txn_ready, // Bank can take a transaction.
   input wire pab_txn_t txn, // Decoded transaction fields.
   output logic rsp_valid, // One-cycle answer strobe.
   output pab_rsp_t rsp, // Answer code and read byte.
   input wire pab_masks_t nvm_masks, // Nonvolatile copy of the masks.
   output pab_masks_t masks, // Masks in force.
   output logic backup_wr, // Pulse: masks changed, update the copy.
   input wire pab_status_t status, // Live status bits.
   output logic alert_active, // Alert is being driven.
   input wire logic alert_i, // Level on the alert line.
   output logic alert_o, // Drive value of the alert line.
   output logic alert_oe_n, // Low while pulling the alert line.
   output logic alert_line_low // Line seen low, synchronised.
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic sel_known(input logic [7:0] sel);
      sel_known = (sel == `PAB_SEL_VOUT) || (sel == `PAB_SEL_IOUT) ||
                  (sel == `PAB_SEL_INPUT) || (sel == `PAB_SEL_TEMP) ||
                  (sel == `PAB_SEL_CML);
   endfunction : sel_known

   function automatic logic [7:0] gate(input logic [7:0] st, input logic [7:0] m,
                                       input logic [7:0] wm);
      gate = st & ~m & wm;
   endfunction : gate

   ////////////////////////////////////////////////////////////////////////////////
   // Link side: capture a transaction and hand it over by toggle.

   typedef enum logic {PAB_L_IDLE, PAB_L_WAIT} pab_link_state_t;

   pab_link_state_t link_state;
   pab_txn_t held_txn;
   logic req_tgl;
   logic ack_sync1;
   logic ack_sync2;
   logic ack_seen;
   logic ack_tgl;
   pab_rsp_t rsp_hold;
   logic link_take;
   logic link_done;

   assign txn_ready = (link_state == PAB_L_IDLE);
   assign link_take = txn_valid && txn_ready;
   assign link_done = (link_state == PAB_L_WAIT) && (ack_sync2 != ack_seen);

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         ack_sync1 <= 1'b0;
         ack_sync2 <= 1'b0;
      end else begin
         ack_sync1 <= ack_tgl;
         ack_sync2 <= ack_sync1;
      end
   end

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         link_state <= PAB_L_IDLE;
         req_tgl <= 1'b0;
         ack_seen <= 1'b0;
      end else begin
         unique case (link_state)
            PAB_L_IDLE: begin
               if (link_take) begin
                  req_tgl <= ~req_tgl;
                  link_state <= PAB_L_WAIT;
               end
            end
            PAB_L_WAIT: begin
               if (link_done) begin
                  ack_seen <= ack_sync2;
                  link_state <= PAB_L_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         held_txn <= '0;
      end else if (link_take) begin
         held_txn <= txn;
      end
   end

   // The answer word is loaded on the device side in the same cycle its toggle moves, and is read only after the toggle is synchronised.
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= link_done;
         if (link_done) begin
            rsp <= rsp_hold;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Device side: receive the toggle and decode the transaction.

   logic req_sync1;
   logic req_sync2;
   logic req_seen;
   logic req_new;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_sync1 <= 1'b0;
         req_sync2 <= 1'b0;
         req_seen <= 1'b0;
      end else begin
         req_sync1 <= req_tgl;
         req_sync2 <= req_sync1;
         req_seen <= req_sync2;
      end
   end

   assign req_new = (req_sync2 != req_seen);

   wire logic is_mine = (held_txn.cmd == `PAB_CMD_ALERT_MASK);
   wire logic all_phases = (held_txn.phase == `PAB_PHASE_ALL);
   wire logic is_wr_word = (held_txn.kind == PAB_KIND_WRITE_WORD);
   wire logic is_proc = (held_txn.kind == PAB_KIND_PROC_CALL);
   wire logic good_sel = sel_known(held_txn.lo);
   wire logic form_ok = is_wr_word || is_proc;
   wire logic do_write = req_new && is_mine && form_ok && is_wr_word && all_phases && good_sel;

   wire logic [7:0] wr_val = held_txn.hi;
   wire logic [7:0] sel = held_txn.lo;

   // Read byte of the selected mask; unwritable bits are stored as zero.
   wire logic [7:0] rd_byte =
      (sel == `PAB_SEL_VOUT) ? masks.alert_mask_output_voltage :
      (sel == `PAB_SEL_IOUT) ? masks.alert_mask_output_current :
      (sel == `PAB_SEL_INPUT) ? masks.alert_mask_input_supply :
      (sel == `PAB_SEL_TEMP) ? masks.alert_mask_thermal :
      (sel == `PAB_SEL_CML) ? masks.alert_mask_comm_logic : `PAB_ZERO_BYTE;

   wire pab_rsp_code_t next_code =
      !is_mine ? PAB_RSP_NOT_MINE :
      !form_ok ? PAB_RSP_BAD_CMD :
      !all_phases ? PAB_RSP_BAD_DATA :
      !good_sel ? PAB_RSP_BAD_DATA : PAB_RSP_OK;

   wire logic [7:0] next_data = (is_mine && is_proc && all_phases && good_sel) ?
                                rd_byte : `PAB_ZERO_BYTE;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_tgl <= 1'b0;
         rsp_hold <= '0;
      end else if (req_new) begin
         rsp_hold <= '{code: next_code, data: next_data};
         ack_tgl <= ~ack_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mask registers.

   logic nvm_loaded;
   pab_masks_t next_masks;

   always_comb begin
      next_masks = masks;
      if (!nvm_loaded) begin
         next_masks.alert_mask_output_voltage = nvm_masks.alert_mask_output_voltage &
                                                `PAB_WMASK_VOUT;
         next_masks.alert_mask_output_current = nvm_masks.alert_mask_output_current &
                                                `PAB_WMASK_IOUT;
         next_masks.alert_mask_input_supply = nvm_masks.alert_mask_input_supply &
                                              `PAB_WMASK_INPUT;
         next_masks.alert_mask_thermal = nvm_masks.alert_mask_thermal &
                                         `PAB_WMASK_TEMP;
         next_masks.alert_mask_comm_logic = nvm_masks.alert_mask_comm_logic &
                                            `PAB_WMASK_CML;
      end else if (do_write) begin
         if (sel == `PAB_SEL_VOUT) begin
            next_masks.alert_mask_output_voltage = wr_val & `PAB_WMASK_VOUT;
         end
         if (sel == `PAB_SEL_IOUT) begin
            next_masks.alert_mask_output_current = wr_val & `PAB_WMASK_IOUT;
         end
         if (sel == `PAB_SEL_INPUT) begin
            next_masks.alert_mask_input_supply = wr_val & `PAB_WMASK_INPUT;
         end
         if (sel == `PAB_SEL_TEMP) begin
            next_masks.alert_mask_thermal = wr_val & `PAB_WMASK_TEMP;
         end
         if (sel == `PAB_SEL_CML) begin
            next_masks.alert_mask_comm_logic = wr_val & `PAB_WMASK_CML;
         end
      end
   end

   // The copy is taken on the first edge after reset release.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nvm_loaded <= 1'b0;
         backup_wr <= 1'b0;
         masks <= '{`PAB_RST_VOUT, `PAB_RST_IOUT, `PAB_RST_INPUT, `PAB_RST_TEMP,
                    `PAB_RST_CML};
      end else begin
         nvm_loaded <= 1'b1;
         backup_wr <= do_write && nvm_loaded;
         masks <= next_masks;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alert drive. Status is only read here, so masking never alters it.

   wire logic [7:0] open_vout = gate(status.vout, masks.alert_mask_output_voltage,
                                     `PAB_WMASK_VOUT);
   wire logic [7:0] open_iout = gate(status.iout, masks.alert_mask_output_current,
                                     `PAB_WMASK_IOUT);
   wire logic [7:0] open_input = gate(status.input_supply, masks.alert_mask_input_supply,
                                      `PAB_WMASK_INPUT);
   wire logic [7:0] open_temp = gate(status.thermal, masks.alert_mask_thermal,
                                     `PAB_WMASK_TEMP);
   wire logic [7:0] open_cml = gate(status.comm_logic, masks.alert_mask_comm_logic,
                                    `PAB_WMASK_CML);
   wire logic next_alert = |{open_vout, open_iout, open_input, open_temp, open_cml};

   logic line_sync1;
   logic line_sync2;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         alert_active <= 1'b0;
         alert_oe_n <= 1'b1;
         line_sync1 <= 1'b1;
         line_sync2 <= 1'b1;
      end else begin
         alert_active <= next_alert;
         alert_oe_n <= ~next_alert;
         line_sync1 <= alert_i;
         line_sync2 <= line_sync1;
      end
   end

   assign alert_o = 1'b0;
   assign alert_line_low = ~line_sync2;

endmodule : pab_alert_mask_bank

// file: pab_alert_mask_bank_props.sv
// Checker of the alert mask bank ports.
`include "pab_cfg.svh"
module pab_alert_mask_bank_props
   import pab_pkg::*;
(
   input wire logic clk, // Clock.
   input wire logic resetn, // Reset.
   input wire logic link_clk, // Link clock.
   input wire logic txn_valid, // Offer.
   input wire logic txn_ready, // Ready.
   input wire pab_txn_t txn, // Fields.
   input wire logic rsp_valid, // Answer.
   input wire pab_rsp_t rsp, // Code, byte.
   input wire pab_masks_t nvm_masks, // Copy.
   input wire pab_masks_t masks, // Masks.
   input wire logic backup_wr, // Backup.
   input wire pab_status_t status, // Status.
   input wire logic alert_active, // Alert.
   input wire logic alert_i, // Line.
   input wire logic alert_o, // Drive.
   input wire logic alert_oe_n, // Enable.
   input wire logic alert_line_low // Seen low.
);
   logic [39:0] wm;
   logic hit;
   logic tk;
   logic mine;
   assign wm = {`PAB_WMASK_VOUT, `PAB_WMASK_IOUT, `PAB_WMASK_INPUT, `PAB_WMASK_TEMP, `PAB_WMASK_CML};
   assign hit = |(status & ~masks & wm);
   assign tk = txn_valid && txn_ready;
   assign mine = tk && txn.cmd == `PAB_CMD_ALERT_MASK;
   ////////////////////////////////////////////////////////////////
   property p_answer;
      @(posedge link_clk) disable iff (!resetn) tk |-> ##[4:12] rsp_valid;
   endproperty
   a_answer: assert property (p_answer) else $error("late answer");
   property p_not_mine;
      @(posedge link_clk) disable iff (!resetn)
         tk && !mine |-> ##[4:12] rsp_valid && rsp.code == PAB_RSP_NOT_MINE;
   endproperty
   a_not_mine: assert property (p_not_mine) else $error("foreign command taken");
   property p_bad_kind;
      @(posedge link_clk) disable iff (!resetn) mine && txn.kind[1]
         |-> ##[4:12] rsp_valid && rsp.code == PAB_RSP_BAD_CMD;
   endproperty
   a_bad_kind: assert property (p_bad_kind) else $error("wrong form taken");
   property p_bad_phase;
      @(posedge link_clk) disable iff (!resetn)
         mine && !txn.kind[1] && txn.phase != `PAB_PHASE_ALL
         |-> ##[4:12] rsp_valid && rsp.code == PAB_RSP_BAD_DATA;
   endproperty
   a_bad_phase: assert property (p_bad_phase) else $error("phase not refused");
   property p_unwritable;
      @(posedge clk) disable iff (!resetn) (masks & ~wm) == 40'h0;
   endproperty
   a_unwritable: assert property (p_unwritable) else $error("bad mask bit");
   property p_alert_follow;
      @(posedge clk) disable iff (!resetn) $past(resetn, 2) |-> alert_oe_n == !$past(hit);
   endproperty
   a_alert_follow: assert property (p_alert_follow) else $error("alert drive wrong");
   property p_alert_active;
      @(posedge clk) disable iff (!resetn) $past(resetn, 2) |-> alert_active == $past(hit);
   endproperty
   a_alert_active: assert property (p_alert_active) else $error("alert flag wrong");
   property p_backup;
      @(posedge clk) disable iff (!resetn) $past(resetn, 2) && $changed(masks) |-> ##[0:2] backup_wr;
   endproperty
   a_backup: assert property (p_backup) else $error("no backup pulse");
   c_ok: cover property (@(posedge link_clk) rsp_valid && rsp.code == PAB_RSP_OK);
   c_alert: cover property (@(posedge clk) !alert_oe_n);
   c_backup: cover property (@(posedge clk) backup_wr);
   c_refused: cover property (@(posedge link_clk) rsp_valid && rsp.code == PAB_RSP_BAD_DATA);
endmodule : pab_alert_mask_bank_props
bind pab_alert_mask_bank pab_alert_mask_bank_props u_props (.clk(clk), .resetn(resetn),
   .link_clk(link_clk), .txn_valid(txn_valid), .txn_ready(txn_ready), .txn(txn),
   .rsp_valid(rsp_valid), .rsp(rsp), .nvm_masks(nvm_masks), .masks(masks), .backup_wr(backup_wr),
   .status(status), .alert_active(alert_active), .alert_i(alert_i), .alert_o(alert_o),
   .alert_oe_n(alert_oe_n), .alert_line_low(alert_line_low));

// file: pab_cfg.svh
// Constants of the alert mask bank: codes, selectors, writable-bit masks, reset values.
`ifndef PAB_CFG_SVH
`define PAB_CFG_SVH

`define PAB_CMD_ALERT_MASK 8'h1B
`define PAB_PHASE_ALL 8'hFF

`define PAB_SEL_VOUT 8'h7A
`define PAB_SEL_IOUT 8'h7B
`define PAB_SEL_INPUT 8'h7C
`define PAB_SEL_TEMP 8'h7D
`define PAB_SEL_CML 8'h7E

`define PAB_WMASK_VOUT 8'hFC
`define PAB_WMASK_IOUT 8'hB0
`define PAB_WMASK_INPUT 8'h08
`define PAB_WMASK_TEMP 8'hC0
`define PAB_WMASK_CML 8'hF2

`define PAB_RST_VOUT 8'hFC
`define PAB_RST_IOUT 8'hB0
`define PAB_RST_INPUT 8'h08
`define PAB_RST_TEMP 8'hC0
`define PAB_RST_CML 8'hF2

`define PAB_ZERO_BYTE 8'h00

`endif

// file: pab_host_model.sv
// Host model offering decoded mask transactions.
module pab_host_model
   import pab_pkg::*;
(
   input wire logic link_clk, // Link clock.
   output logic txn_valid, // Offer.
   input wire logic txn_ready, // Ready.
   output pab_txn_t txn, // Fields.
   input wire logic rsp_valid, // Answer.
   input wire pab_rsp_t rsp // Code, byte.
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      txn_valid = 1'b0;
      txn = '0;
   end
   // Fields are scrambled after the handshake so a late sample cannot pass.
   task automatic xfer(input pab_kind_t k, input logic [7:0] c, ph, lo, hi, output pab_rsp_t r);
      int n;
      r = 'x;
      @(negedge link_clk);
      for (n = 0; n < 20 && !txn_ready; n++) @(negedge link_clk);
      txn = '{k, c, ph, lo, hi};
      txn_valid = 1'b1;
      @(posedge link_clk);
      @(negedge link_clk);
      txn_valid = 1'b0;
      txn = ~txn;
      for (n = 0; n < 16 && !rsp_valid; n++) @(negedge link_clk);
      if (rsp_valid) r = rsp;
   endtask : xfer
endmodule : pab_host_model

// file: pab_pkg.sv
// Types shared by the alert mask bank and its environment.
package pab_pkg;

   typedef enum logic [1:0] {
      PAB_KIND_WRITE_WORD,
      PAB_KIND_PROC_CALL,
      PAB_KIND_OTHER_WRITE,
      PAB_KIND_OTHER_READ
   } pab_kind_t;

   typedef enum logic [1:0] {
      PAB_RSP_OK,
      PAB_RSP_BAD_CMD,
      PAB_RSP_BAD_DATA,
      PAB_RSP_NOT_MINE
   } pab_rsp_code_t;

   typedef struct packed {
      pab_kind_t kind;
      logic [7:0] cmd;
      logic [7:0] phase;
      logic [7:0] lo;
      logic [7:0] hi;
   } pab_txn_t;

   typedef struct packed {
      pab_rsp_code_t code;
      logic [7:0] data;
   } pab_rsp_t;

   typedef struct packed {
      logic [7:0] alert_mask_output_voltage;
      logic [7:0] alert_mask_output_current;
      logic [7:0] alert_mask_input_supply;
      logic [7:0] alert_mask_thermal;
      logic [7:0] alert_mask_comm_logic;
   } pab_masks_t;

   typedef struct packed {
      logic [7:0] vout;
      logic [7:0] iout;
      logic [7:0] input_supply;
      logic [7:0] thermal;
      logic [7:0] comm_logic;
   } pab_status_t;

endpackage : pab_pkg

// file: test_pmbus_alert_mask_bank.sv
// Testbench of the alert mask bank.
`include "pab_cfg.svh"
module test_pmbus_alert_mask_bank
   import pab_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0;
   logic link_clk = 0;
   logic resetn = 0;
   logic txn_valid, txn_ready, rsp_valid, backup_wr, alert_active, alert_o, alert_oe_n, alert_line_low;
   pab_txn_t txn;
   pab_rsp_t rsp, r;
   pab_masks_t nvm_masks = {5{8'hA5}};
   pab_masks_t masks;
   pab_status_t status = '0;
   wire alert_i = alert_oe_n ? 1'b1 : alert_o;
   int miscompares = 0;
   int compares = 0;
   int backups = 0;
   // Counts the pulses that ask for the nonvolatile copy to be updated.
   always @(negedge clk) begin
      if (backup_wr) backups++;
   end
   localparam logic [7:0] SEL [5] = '{8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E};
   localparam logic [7:0] WM [5] = '{8'hFC, 8'hB0, 8'h08, 8'hC0, 8'hF2};
   initial forever #50 clk = ~clk;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end
   pab_alert_mask_bank dut (.clk(clk), .resetn(resetn), .link_clk(link_clk), .txn_valid(txn_valid),
      .txn_ready(txn_ready), .txn(txn), .rsp_valid(rsp_valid), .rsp(rsp), .nvm_masks(nvm_masks),
      .masks(masks), .backup_wr(backup_wr), .status(status), .alert_active(alert_active),
      .alert_i(alert_i), .alert_o(alert_o), .alert_oe_n(alert_oe_n), .alert_line_low(alert_line_low));
   pab_host_model host (.link_clk(link_clk), .txn_valid(txn_valid), .txn_ready(txn_ready),
      .txn(txn), .rsp_valid(rsp_valid), .rsp(rsp));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic go(input pab_kind_t k, input logic [7:0] sel, v);
      host.xfer(k, `PAB_CMD_ALERT_MASK, `PAB_PHASE_ALL, sel, v, r);
   endtask : go
   task automatic clks(input int n);
      repeat (n) @(negedge clk);
   endtask : clks
   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic t_load;
      for (int i = 0; i < 5; i++) chk("loaded", masks[39-8*i -: 8], 8'hA5 & WM[i]);
      $display("test load done");
   endtask : t_load
   task automatic t_rw;
      for (int i = 0; i < 5; i++) begin
         go(PAB_KIND_WRITE_WORD, SEL[i], 8'hFF);
         chk("write code", 8'(r.code), 8'h00);
         chk("in force", masks[39-8*i -: 8], WM[i]);
         go(PAB_KIND_PROC_CALL, SEL[i], 8'h00);
         chk("read", r.data, WM[i]);
         go(PAB_KIND_WRITE_WORD, SEL[i], 8'h00);
         go(PAB_KIND_PROC_CALL, SEL[i], 8'h00);
         chk("read zero", r.data, 8'h00);
      end
      chk("backups", 8'(backups), 8'h0A);
      $display("test write read done");
   endtask : t_rw
   task automatic t_refuse;
      pab_kind_t k [5] = '{PAB_KIND_WRITE_WORD, PAB_KIND_OTHER_WRITE, PAB_KIND_OTHER_READ,
         PAB_KIND_WRITE_WORD, PAB_KIND_WRITE_WORD};
      logic [7:0] c [5] = '{8'h1A, 8'h1B, 8'h1B, 8'h1B, 8'h1B};
      logic [7:0] ph [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'hFF};
      logic [7:0] s [5] = '{8'h7D, 8'h7D, 8'h7D, 8'h7D, 8'h7F};
      pab_rsp_code_t e [5] = '{PAB_RSP_NOT_MINE, PAB_RSP_BAD_CMD, PAB_RSP_BAD_CMD,
         PAB_RSP_BAD_DATA, PAB_RSP_BAD_DATA};
      for (int i = 0; i < 5; i++) begin
         host.xfer(k[i], c[i], ph[i], s[i], 8'hC0, r);
         chk("refusal", 8'(r.code), 8'(e[i]));
      end
      chk("mask kept", masks[15:8], 8'h00);
      chk("no backup", 8'(backups), 8'h0A);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_alert;
      clks(1);
      status.thermal = 8'h01;
      clks(3);
      chk("unused bit", 8'(alert_oe_n), 8'h01);
      status.thermal = 8'h80;
      clks(3);
      chk("alert", 8'(alert_oe_n), 8'h00);
      chk("active", 8'(alert_active), 8'h01);
      chk("drive level", 8'(alert_o), 8'h00);
      clks(2);
      chk("line low", 8'(alert_line_low), 8'h01);
      go(PAB_KIND_WRITE_WORD, 8'h7D, 8'h80);
      clks(3);
      chk("masked", 8'(alert_oe_n), 8'h01);
      status.comm_logic = 8'h02;
      clks(3);
      chk("comm alert", 8'(alert_oe_n), 8'h00);
      status = '0;
      clks(3);
      chk("released", 8'(alert_oe_n), 8'h01);
      chk("line high", 8'(alert_line_low), 8'h00);
      $display("test alert done");
   endtask : t_alert
   initial begin
      clks(16);
      resetn = 1'b1;
      clks(4);
      t_load;
      t_rw;
      t_refuse;
      t_alert;
      stop_test;
   end
   initial begin
      #400000;
      miscompares++;
      stop_test;
   end
endmodule : test_pmbus_alert_mask_bank
